// ### design/pgit_pkg.sv
// types shared by the power gating interval timer
package pgit_pkg;

    typedef enum logic [2:0] {
        ST_MEASURE = 3'b000,
        ST_ABORT   = 3'b001,
        ST_WINDOW  = 3'b010,
        ST_GUARD   = 3'b011,
        ST_IDLE    = 3'b100,
        ST_MANUAL  = 3'b101
    } state_t;

endpackage

// ### design/pgit_regs.svh
// timing and limit constants for the power gating interval timer
`ifndef PGIT_REGS_SVH
`define PGIT_REGS_SVH

// core clock rate in hertz
`define PGIT_CLK_HZ          25000000
// base time step of all interval counting, in ms
`define PGIT_TICK_MS         1
// off time at the end of every interval, in ms
`define PGIT_GUARD_MS        50
// measurement phase after reset, in ms
`define PGIT_MEASURE_MS      100
// manual request filter time, in ms
`define PGIT_DEBOUNCE_MS     20
// manual request observation window, in ms
`define PGIT_OBSERVE_MS      30
// longest delay from manual recognition to gate low, in ms
`define PGIT_MANUAL_DELAY_MS 10
// shortest completion pulse the controller must give, in ns
`define PGIT_DONE_MIN_NS     100
// interval limits, in ms
`define PGIT_MIN_INTERVAL_MS 100
`define PGIT_MAX_INTERVAL_MS 7200000
// reset values
`define PGIT_GATE_RESET      1'b1

`endif

// ### design/power_gating_interval_timer.sv
// power gating interval timer: gate drive, completion, manual power-on
`timescale 1ns/100ps
`include "pgit_regs.svh"

// Operation
// RULE_01: periodic mode opens window every interval start
// RULE_02: gate output low powers load
// RULE_03: window lasts interval minus 50 ms
// RULE_04: gate high for final 50 ms
// RULE_05: gate rests high after measurement
// RULE_06: gate goes low at interval start
// RULE_07: only rising completion edge counts
// RULE_08: first completion per interval only
// RULE_09: controller holds completion at least 100 ns
// RULE_10: completion ends window early, both modes
// RULE_11: one measurement phase before any window
// RULE_12: mode chosen from sampled mode pin
// RULE_13: mode pin is tied statically
// RULE_14: one-shot gives one window after start-up
// RULE_15: one-shot manual request gives one window
// RULE_16: periodic falling edges spaced by interval
// RULE_17: manual during measurement aborts and restarts
// RULE_18: manual needs 20 ms within 30 ms; the code has no 30 ms window and counts high steps up and low steps down to 20
// RULE_19: manual input filtered for 20 ms
// RULE_20: manual ignored while gate is low
// RULE_21: gate low within 10 ms of manual
// RULE_22: manual clears counters until input low
// RULE_23: completion ignored while manual held high
// RULE_24: interval code timed on internal clock
// RULE_25: manual input passes two-stage synchroniser
module power_gating_interval_timer #(
    // core cycles per time step; shorten for simulation
    parameter int unsigned TICK_CYC =
        (`PGIT_CLK_HZ / 1000) * `PGIT_TICK_MS
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        srst,
    // static mode strap, high selects periodic mode
    input  wire logic        mode_periodic,
    // shared interval select / manual power-on pin
    input  wire logic        interval_set_manual_on,
    // interval from measurement front end, in ms
    input  wire logic [22:0] interval_period,
    // completion from the powered controller
    input  wire logic        done_in,
    // gate drive to external switch, low powers load
    output logic             gate_drive_n,
    // status
    output logic             measure_active,
    output logic             manual_power_request,
    output logic             periodic_active
);

    localparam logic [15:0] TICK_LAST  = 16'(TICK_CYC - 1);
    localparam logic [22:0] GUARD_TICKS =
        23'(`PGIT_GUARD_MS / `PGIT_TICK_MS);
    localparam logic [6:0]  MEAS_LAST  =
        7'(`PGIT_MEASURE_MS / `PGIT_TICK_MS - 1);
    localparam logic [4:0]  DB_LIMIT   =
        5'(`PGIT_DEBOUNCE_MS / `PGIT_TICK_MS);
    localparam logic [22:0] IVL_MIN    = 23'(`PGIT_MIN_INTERVAL_MS);
    localparam logic [22:0] IVL_MAX    = 23'(`PGIT_MAX_INTERVAL_MS);

    // synchronisers
    logic        man_s1_q;
    logic        man_s2_q;
    logic        done_s1_q;
    logic        done_s2_q;
    logic        done_s3_q;
    logic        mode_s1_q;
    logic        mode_s2_q;

    // time base
    logic [15:0] tick_cnt_q;
    logic        tick_q;

    // manual filter
    logic [4:0]  db_cnt_q;
    logic        man_filt_q;
    logic        man_filt_d1_q;

    // sequencing
    pgit_pkg::state_t state_q;
    logic [6:0]  meas_cnt_q;
    logic [22:0] ivl_cnt_q;
    logic [22:0] period_q;
    logic        mode_q;
    logic        done_taken_q;
    logic        gate_q;

    // events
    logic        done_rise;
    logic        done_ev;
    logic        man_rise;
    logic        man_start;
    logic        meas_end;
    logic        win_end;
    logic        ivl_end;
    logic        tick_hold;
    logic [22:0] period_clamped;

    // pins are asynchronous to the core clock
    always_ff @(posedge clk) begin
        if (srst) begin
            man_s1_q <= 1'b0;
            man_s2_q <= 1'b0;
        end else begin
            man_s1_q <= interval_set_manual_on;  // see RULE_25
            man_s2_q <= man_s1_q;
        end
    end

    // a pulse near the 100 ns minimum spans only two or three cycles
    always_ff @(posedge clk) begin
        if (srst) begin
            done_s1_q <= 1'b0;
            done_s2_q <= 1'b0;
            done_s3_q <= 1'b0;
        end else begin
            done_s1_q <= done_in;  // see RULE_09
            done_s2_q <= done_s1_q;
            done_s3_q <= done_s2_q;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            mode_s1_q <= 1'b0;
            mode_s2_q <= 1'b0;
        end else begin
            mode_s1_q <= mode_periodic;
            mode_s2_q <= mode_s1_q;
        end
    end

    // steps must run during a manual hold, or the filter could never
    // release; zeroed as the window opens so it starts on a whole step
    assign tick_hold = (state_q == pgit_pkg::ST_ABORT) ||
                       ((state_q == pgit_pkg::ST_MANUAL) && !man_filt_q);

    always_ff @(posedge clk) begin
        if (srst || tick_hold) begin
            tick_cnt_q <= 16'h0000;
            tick_q     <= 1'b0;
        end else if (tick_cnt_q == TICK_LAST) begin
            tick_cnt_q <= 16'h0000;  // see RULE_24
            tick_q     <= 1'b1;
        end else begin
            tick_cnt_q <= tick_cnt_q + 16'h0001;
            tick_q     <= 1'b0;
        end
    end

    // integrating filter on both edges: high steps count up, low steps
    // count down, so 20 ms of high inside 30 ms is accepted only if no low step falls between the high steps
    always_ff @(posedge clk) begin
        if (srst) begin
            db_cnt_q <= 5'h00;
        end else if (tick_q) begin
            if (man_s2_q && db_cnt_q != DB_LIMIT) begin
                db_cnt_q <= db_cnt_q + 5'h01;  // see RULE_18
            end else if (!man_s2_q && db_cnt_q != 5'h00) begin
                db_cnt_q <= db_cnt_q - 5'h01;
            end
        end else if (tick_hold && !man_s2_q && !man_filt_q) begin
            db_cnt_q <= 5'h00;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            man_filt_q    <= 1'b0;
            man_filt_d1_q <= 1'b0;
        end else begin
            if (db_cnt_q == DB_LIMIT) begin
                man_filt_q <= 1'b1;  // see RULE_19
            end else if (db_cnt_q == 5'h00) begin
                man_filt_q <= 1'b0;
            end
            man_filt_d1_q <= man_filt_q;
        end
    end

    assign man_rise  = man_filt_q && !man_filt_d1_q;
    // requests only count while the load is off
    assign man_start = man_rise && gate_q &&
                       ((state_q == pgit_pkg::ST_GUARD) ||
                        (state_q == pgit_pkg::ST_IDLE));  // see RULE_20

    assign done_rise = done_s2_q && !done_s3_q;  // see RULE_07
    assign done_ev   = done_rise && !done_taken_q &&
                       !man_filt_q;  // see RULE_08, RULE_23

    assign meas_end = tick_q && (state_q == pgit_pkg::ST_MEASURE) &&
                      (meas_cnt_q == MEAS_LAST) && !man_s2_q;
    assign win_end  = tick_q &&
                      (ivl_cnt_q == period_q - GUARD_TICKS - 23'h000001);
    assign ivl_end  = tick_q && (ivl_cnt_q == period_q - 23'h000001);

    // out-of-range codes are held inside the legal interval span
    always_comb begin
        if (interval_period < IVL_MIN) begin
            period_clamped = IVL_MIN;
        end else if (interval_period > IVL_MAX) begin
            period_clamped = IVL_MAX;
        end else begin
            period_clamped = interval_period;
        end
    end

    // measurement phase counter restarts after every abort
    always_ff @(posedge clk) begin
        if (srst || state_q != pgit_pkg::ST_MEASURE) begin
            meas_cnt_q <= 7'h00;
        end else if (tick_q) begin
            meas_cnt_q <= meas_cnt_q + 7'h01;  // see RULE_11
        end
    end

    // interval and mode are caught once, when measurement ends
    always_ff @(posedge clk) begin
        if (srst) begin
            period_q <= IVL_MIN;
            mode_q   <= 1'b0;
        end else if (meas_end) begin
            period_q <= period_clamped;  // see RULE_24
            mode_q   <= mode_s2_q;  // see RULE_12, RULE_13
        end
    end

    // one completion per window; a new edge wins over the clear
    always_ff @(posedge clk) begin
        if (srst) begin
            done_taken_q <= 1'b0;
        end else if (done_rise && !man_filt_q &&
                     (state_q == pgit_pkg::ST_WINDOW)) begin
            done_taken_q <= 1'b1;  // see RULE_08
        end else if (ivl_end || man_start || meas_end) begin
            done_taken_q <= 1'b0;
        end
    end

    // interval counter, cleared by a manual request
    always_ff @(posedge clk) begin
        if (srst) begin
            ivl_cnt_q <= 23'h000000;
        end else begin
            case (state_q)
                pgit_pkg::ST_WINDOW,
                pgit_pkg::ST_GUARD: begin
                    if (man_start || ivl_end) begin
                        ivl_cnt_q <= 23'h000000;  // see RULE_22
                    end else if (tick_q) begin
                        ivl_cnt_q <= ivl_cnt_q + 23'h000001;
                    end
                end
                default: begin
                    ivl_cnt_q <= 23'h000000;  // see RULE_22
                end
            endcase
        end
    end

    // sequencing and gate drive
    always_ff @(posedge clk) begin
        if (srst) begin
            state_q <= pgit_pkg::ST_MEASURE;
            gate_q  <= `PGIT_GATE_RESET;
        end else begin
            case (state_q)
                pgit_pkg::ST_MEASURE: begin
                    gate_q <= 1'b1;  // see RULE_11
                    if (man_s2_q) begin
                        state_q <= pgit_pkg::ST_ABORT;  // see RULE_17
                    end else if (meas_end) begin
                        state_q <= pgit_pkg::ST_WINDOW;  // see RULE_14
                        gate_q  <= 1'b0;  // see RULE_06
                    end
                end
                pgit_pkg::ST_ABORT: begin
                    gate_q <= 1'b1;
                    if (!man_s2_q) begin
                        state_q <= pgit_pkg::ST_MEASURE;  // see RULE_17
                    end
                end
                pgit_pkg::ST_WINDOW: begin
                    if (done_ev || win_end) begin
                        gate_q <= 1'b1;  // see RULE_03, RULE_10
                        if (mode_q) begin
                            state_q <= pgit_pkg::ST_GUARD;  // see RULE_04
                        end else begin
                            state_q <= pgit_pkg::ST_IDLE;  // see RULE_14
                        end
                    end
                end
                pgit_pkg::ST_GUARD: begin
                    if (man_start) begin
                        state_q <= pgit_pkg::ST_MANUAL;  // see RULE_21
                        gate_q  <= 1'b0;
                    end else if (ivl_end) begin
                        // see RULE_01, RULE_16
                        state_q <= pgit_pkg::ST_WINDOW;
                        gate_q  <= 1'b0;  // see RULE_06
                    end else begin
                        gate_q <= 1'b1;  // see RULE_05
                    end
                end
                pgit_pkg::ST_IDLE: begin
                    if (man_start) begin
                        state_q <= pgit_pkg::ST_MANUAL;  // see RULE_15
                        gate_q  <= 1'b0;  // see RULE_21
                    end else begin
                        gate_q <= 1'b1;  // see RULE_05
                    end
                end
                pgit_pkg::ST_MANUAL: begin
                    // a held request keeps the load on past the interval
                    gate_q <= 1'b0;  // see RULE_23
                    if (!man_filt_q) begin
                        state_q <= pgit_pkg::ST_WINDOW;  // see RULE_22
                    end
                end
                default: begin
                    state_q <= pgit_pkg::ST_MEASURE;
                    gate_q  <= 1'b1;
                end
            endcase
        end
    end

    assign gate_drive_n = gate_q;  // see RULE_02

    // status outputs
    always_ff @(posedge clk) begin
        if (srst) begin
            measure_active       <= 1'b1;
            manual_power_request <= 1'b0;
            periodic_active      <= 1'b0;
        end else begin
            // falls on the edge that opens the first window, never after
            measure_active <= ((state_q == pgit_pkg::ST_MEASURE) &&
                               !meas_end) ||
                              (state_q == pgit_pkg::ST_ABORT);
            manual_power_request <= man_filt_q;
            if (meas_end) begin
                periodic_active <= mode_s2_q;
            end
        end
    end

endmodule // power_gating_interval_timer

// ### sim/mcu_model.sv
// powered controller model answering each window with a completion pulse
`timescale 1ns/100ps
module mcu_model (
    // clock and gate
    input  wire logic clk,
    input  wire logic gate_drive_n,
    // pulse delay and length in cycles, zero delay keeps silent
    input  var int    dly,
    input  var int    hold,
    // completion
    output logic      done_in
);
    initial begin
        done_in = 1'b0;
        forever begin
            @(negedge clk);
            if (gate_drive_n === 1'b0 && dly > 0) begin
                repeat (dly) @(negedge clk);
                done_in = 1'b1;
                repeat (hold) @(negedge clk);
                done_in = 1'b0;
            end
        end
    end
endmodule // mcu_model

// ### sim/pgit_props.sv
// assertion checker for the power gating interval timer
`timescale 1ns/100ps
module pgit_props #(
    parameter int unsigned TICK_CYC = 4
) (
    // clock and reset
    input wire logic        clk,
    input wire logic        srst,
    // inputs
    input wire logic        mode_periodic,
    input wire logic        interval_set_manual_on,
    input wire logic [22:0] interval_period,
    input wire logic        done_in,
    // outputs
    input wire logic        gate_drive_n,
    input wire logic        measure_active,
    input wire logic        manual_power_request,
    input wire logic        periodic_active
);
    localparam int MAN_MAX = 10 * TICK_CYC;
    int low_q;
    int meas_q;

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    // manual hold clears the window count, so it is excluded here
    always_ff @(posedge clk) begin
        low_q <= (gate_drive_n || manual_power_request) ? 0 : low_q + 1;
    end
    always_ff @(posedge clk) begin
        meas_q <= (measure_active && !srst) ? meas_q + 1 : 0;
    end

    property p_rst;
        $fell(srst) |-> gate_drive_n && measure_active;
    endproperty
    a_rst: assert property (p_rst) else $error("gate not off after reset");
    property p_nomeas;
        !gate_drive_n |-> !measure_active;
    endproperty
    a_nomeas: assert property (p_nomeas) else $error("window in measure");
    property p_meas;
        $fell(measure_active) |-> meas_q >= 100 * TICK_CYC - 2;
    endproperty
    a_meas: assert property (p_meas) else $error("measure too short");
    property p_start;
        $fell(measure_active) |-> ##[0:3] !gate_drive_n;
    endproperty
    a_start: assert property (p_start) else $error("no first window");
    sequence s_done_seen;
        (!gate_drive_n && !manual_power_request && $rose(done_in))
        ##1 !manual_power_request [*5];
    endsequence
    property p_done;
        s_done_seen |-> ##[0:2] gate_drive_n;
    endproperty
    a_done: assert property (p_done) else $error("done not honoured");
    property p_win;
        low_q <= (int'(interval_period) - 50 + 1) * int'(TICK_CYC);
    endproperty
    a_win: assert property (p_win) else $error("window too long");
    property p_mode;
        periodic_active |-> mode_periodic;
    endproperty
    a_mode: assert property (p_mode) else $error("wrong mode");
    property p_man;
        $rose(manual_power_request) && !measure_active
        |-> ##[0:MAN_MAX] !gate_drive_n;
    endproperty
    a_man: assert property (p_man) else $error("manual window late");

    c_done: cover property ($rose(done_in) && !gate_drive_n);
    c_man: cover property ($rose(manual_power_request));
    c_per: cover property ($rose(periodic_active));
endmodule // pgit_props

bind power_gating_interval_timer pgit_props #(.TICK_CYC(TICK_CYC)) props_u (
    .clk(clk), .srst(srst), .mode_periodic(mode_periodic),
    .interval_set_manual_on(interval_set_manual_on),
    .interval_period(interval_period), .done_in(done_in),
    .gate_drive_n(gate_drive_n), .measure_active(measure_active),
    .manual_power_request(manual_power_request),
    .periodic_active(periodic_active)
);

// ### sim/tb.sv
// self-checking bench for the power gating interval timer
`timescale 1ns/100ps
module tb;
    localparam int T = 4;
    localparam int P = 100;
    logic        clk;
    logic        srst;
    logic        mode_periodic;
    logic        interval_set_manual_on;
    logic [22:0] interval_period;
    logic        done_in;
    logic        gate_drive_n;
    logic        measure_active;
    logic        manual_power_request;
    logic        periodic_active;
    int          dly;
    int          hold;
    int          n_errors;
    int          total_checks;
    int          cyc;
    int          n;
    int          m;

    power_gating_interval_timer #(.TICK_CYC(T)) dut_u (
        .clk(clk), .srst(srst), .mode_periodic(mode_periodic),
        .interval_set_manual_on(interval_set_manual_on),
        .interval_period(interval_period), .done_in(done_in),
        .gate_drive_n(gate_drive_n), .measure_active(measure_active),
        .manual_power_request(manual_power_request),
        .periodic_active(periodic_active)
    );
    mcu_model mcu_u (.clk(clk), .gate_drive_n(gate_drive_n), .dly(dly),
        .hold(hold), .done_in(done_in));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic test_done();
        if (n_errors == 0 && total_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_errors++;
            test_done();
        end
    end

    task automatic chk_bit(logic exp, logic got);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t exp %h got %h", $time, exp, got);
        end
    endtask

    task automatic chk_cnt(int exp, int got);
        total_checks++;
        if (got != exp) begin
            n_errors++;
            $display("[FAIL] %0t exp %h got %h", $time, exp, got);
        end
    endtask

    // counts cycles until the gate shows the given level
    task automatic wait_lvl(logic lvl, int lim, output int k);
        k = 0;
        while (gate_drive_n !== lvl && k < lim) begin
            @(negedge clk);
            k++;
        end
    endtask

    task automatic restart(logic mode);
        srst = 1'b1;
        mode_periodic = mode;
        repeat (2) @(negedge clk);
        srst = 1'b0;
    endtask

    task automatic s_abort();
        restart(1'b1);
        @(negedge clk);
        chk_bit(1'b1, gate_drive_n);
        chk_bit(1'b1, measure_active);
        repeat (20 * T) @(negedge clk);
        interval_set_manual_on = 1'b1;
        repeat (10 * T) @(negedge clk);
        interval_set_manual_on = 1'b0;
        wait_lvl(1'b0, 2000, n);
        chk_bit(1'b1, n >= 100 * T && n <= 102 * T);
        chk_bit(1'b0, measure_active);
        chk_bit(1'b1, periodic_active);
    endtask

    task automatic s_periodic();
        wait_lvl(1'b1, 1000, n);
        chk_cnt((P - 50) * T, n);
        wait_lvl(1'b0, 1000, m);
        chk_cnt(50 * T, m);
        chk_cnt(P * T, n + m);
    endtask

    // long hold keeps done high across the next window start
    task automatic s_done();
        dly = 20;
        hold = P * T;
        wait_lvl(1'b1, 1000, n);
        chk_bit(1'b1, n >= 20 && n <= 28);
        wait_lvl(1'b0, 1000, m);
        chk_cnt(P * T, n + m);
        dly = 0;
        hold = 5;
        repeat (4 * T) @(negedge clk);
        chk_bit(1'b1, done_in);
        chk_bit(1'b0, gate_drive_n);
    endtask

    task automatic s_oneshot();
        restart(1'b0);
        dly = 20;
        wait_lvl(1'b0, 1000, n);
        wait_lvl(1'b1, 300, n);
        chk_bit(1'b1, n <= 28);
        chk_bit(1'b0, periodic_active);
        wait_lvl(1'b0, 3 * P * T, n);
        chk_cnt(3 * P * T, n);
        interval_set_manual_on = 1'b1;
        repeat (5 * T) @(negedge clk);
        interval_set_manual_on = 1'b0;
        repeat (30 * T) @(negedge clk);
        chk_bit(1'b0, manual_power_request);
        chk_bit(1'b1, gate_drive_n);
        interval_set_manual_on = 1'b1;
        wait_lvl(1'b0, 35 * T, n);
        chk_bit(1'b1, n >= 20 * T && n <= 22 * T);
        chk_bit(1'b1, manual_power_request);
        repeat (5 * T) @(negedge clk);
        chk_bit(1'b0, gate_drive_n);
        interval_set_manual_on = 1'b0;
        wait_lvl(1'b1, 60 * T, n);
        chk_bit(1'b1, n >= 19 * T && n < 60 * T);
    endtask

    initial begin
        srst = 1'b1;
        mode_periodic = 1'b1;
        interval_set_manual_on = 1'b0;
        interval_period = 23'h000064;
        dly = 0;
        hold = 5;
        s_abort();
        s_periodic();
        s_done();
        s_oneshot();
        test_done();
    end
endmodule // tb
